// [common/fault_log_params.svh]
// Offsets, field positions and sizes of the error logging block
`ifndef FAULT_LOG_PARAMS_SVH
`define FAULT_LOG_PARAMS_SVH

`define NSTRAND 8
`define STRAND_W 3
`define SYNC_LANES 2
`define ASYNC_LANES 2

// Alternate space numbers and in-space offsets
`define ASI_FAULT_LOG 8'h4c
`define ASI_DATA_FAULT 8'h58
`define OFS_ASYNC_LOG 8'h00
`define OFS_KIND_REG 8'h18
`define OFS_LOCATOR_REG 8'h20

// Register widths
`define KIND_W 4
`define LOC_W 48
`define LOG_KIND_W 5
`define LOG_LOC_W 11

// Asynchronous log field positions
`define LOG_VALID_BIT 63
`define LOG_OVERRUN_BIT 62
`define LOG_CLASS_BIT 61
`define LOG_KIND_LSB 56
`define LOG_LOC_LSB 0

// Locator classes
`define CLS_XLATE 4'h1
`define CLS_WALK_CFG 4'h2
`define CLS_MEMORY 4'h3
`define CLS_ICACHE 4'h4
`define CLS_DCACHE 4'h5
`define CLS_STB 4'h6
`define CLS_IRF 4'h8
`define CLS_FRF 4'h9
`define CLS_CFG_ARRAY 4'ha
`define CLS_TSTACK 4'hb
`define CLS_SCRATCH 4'hc
`define CLS_TICK 4'hd

// Integer register file physical bases
`define IRF_GLOBAL_BASE 5'h00
`define IRF_LOW_WIN_BASE 5'h08
`define IRF_LOCAL_BASE 5'h10
`define IRF_HIGH_WIN_BASE 5'h18

// Reset value and the no-rank marker
`define KIND_RESET 4'h0
`define RANK_NONE 8'hff

`endif

// [common/fault_log_pkg.sv]
// Types shared by the error logging block
package fault_log_pkg;
   `include "fault_log_params.svh"

   // Raw locator material from a detector; formatted per class inside
   typedef struct packed {
      logic [3:0] cls;
      logic [47:0] va;
      logic [6:0] idx;
      logic [2:0] way;
      logic [7:0] syn_a;
      logic [7:0] syn_b;
      logic [1:0] gl;
      logic win_odd;
   } loc_src_t;

   typedef struct packed {
      logic vld;
      logic [3:0] kind;
      logic [3:0] prio;
      loc_src_t loc;
   } sync_lane_t;

   typedef struct packed {
      logic vld;
      logic [2:0] strand;
      logic [4:0] kind;
      logic rep_en;
      loc_src_t loc;
   } async_lane_t;

   typedef struct packed {
      logic valid;
      logic overrun;
      logic recov;
      logic [4:0] kind;
      logic [10:0] loc;
   } async_log_t;

   typedef enum logic [1:0] {
      ACC_LOG = 2'b00,
      ACC_KIND = 2'b01,
      ACC_LOCATOR = 2'b10,
      ACC_NONE = 2'b11
   } acc_target_t;
endpackage : fault_log_pkg

// [common/loc_store_if.sv]
// Carrier between the logger and its locator store
`timescale 1ns/1ns
interface loc_store_if;
   logic wr_en;
   logic [2:0] wr_addr;
   logic [47:0] wr_data;
   logic [2:0] rd_addr;
   logic [47:0] rd_data;

   modport user (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
   modport store (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface : loc_store_if

// [logic/loc_store.sv]
// Per-strand storage of the 48-bit fault locator
`timescale 1ns/1ns
module loc_store (
   input wire logic clk_i,
   loc_store_if.store port
);
   logic [47:0] mem [0:7];

   // No reset on purpose: loc_written in the logger, cleared by every reset, masks stale contents
   always_ff @(posedge clk_i) begin
      if (port.wr_en) begin
         mem[port.wr_addr] <= port.wr_data;
      end
   end

   always_ff @(posedge clk_i) begin
      port.rd_data <= mem[port.rd_addr];
   end
endmodule : loc_store

// [logic/fault_logger.sv]
// Per-strand precise fault registers and disrupting error log
`timescale 1ns/1ns
`include "fault_log_params.svh"
module fault_logger
   import fault_log_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Alternate-space access port
   input wire logic acc_req_i,
   input wire logic acc_wr_i,
   input wire logic [2:0] acc_strand_i,
   input wire logic [7:0] acc_asi_i,
   input wire logic [7:0] acc_ofs_i,
   input wire logic [63:0] acc_wdata_i,
   output logic acc_ack_o,
   output logic acc_err_o,
   output logic [63:0] acc_rdata_o,
   // Precise error lanes, all for one access of one strand
   input wire logic [2:0] sync_strand_i,
   input wire sync_lane_t [1:0] sync_lane_i,
   // Disrupting error lanes
   input wire async_lane_t [1:0] corr_lane_i,
   input wire async_lane_t [1:0] recov_lane_i,
   // Per-strand trap gating
   input wire logic [7:0] fixed_trap_on_i,
   input wire logic [7:0] recov_trap_on_i,
   input wire logic [7:0] intr_allow_i,
   input wire logic [7:0] top_level_mode_i,
   output logic [7:0] fixed_fault_trap_o,
   output logic [7:0] recoverable_fault_trap_o
);
   logic rst_meta;
   logic rst_n;
   async_log_t async_fault_log [0:7];
   async_log_t next_log [0:7];
   logic [3:0] data_fault_kind_reg [0:7];
   logic [7:0] loc_written;
   logic sync_hit;
   logic [3:0] sync_kind;
   logic [47:0] sync_loc;
   logic rd_log;
   acc_target_t target;
   acc_target_t target_q;
   logic [63:0] rdata_q;
   logic loc_valid_q;

   loc_store_if loc_if ();

   loc_store u_store (
      .clk_i(core_clk_i),
      .port(loc_if.store)
   );

   // Reset is released through two flops
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n <= rst_meta;
      end
   end

   // Maps a logical integer register to its physical array slot
   function automatic logic [4:0] irf_phys(input logic [4:0] lreg,
                                           input logic odd);
      logic [4:0] base;
      base = `IRF_GLOBAL_BASE;
      case (lreg[4:3])
         2'h0: base = `IRF_GLOBAL_BASE;
         2'h1: base = odd ? `IRF_HIGH_WIN_BASE : `IRF_LOW_WIN_BASE;
         2'h2: base = `IRF_LOCAL_BASE;
         2'h3: base = odd ? `IRF_LOW_WIN_BASE : `IRF_HIGH_WIN_BASE;
         default: base = `IRF_GLOBAL_BASE;
      endcase
      return base | {2'h0, lreg[2:0]};
   endfunction : irf_phys

   // Formats the locator word for its error class
   function automatic logic [47:0] pack_loc(input loc_src_t s);
      logic [47:0] w;
      w = '0;
      case (s.cls)
         `CLS_XLATE: w = s.va;
         `CLS_WALK_CFG: w[2:0] = s.idx[2:0];
         `CLS_ICACHE: w[8:0] = {s.way, s.idx[5:0]};
         `CLS_DCACHE: w[8:0] = {s.way[1:0], s.idx};
         `CLS_STB, `CLS_CFG_ARRAY: w[2:0] = s.idx[2:0];
         `CLS_IRF: w[14:0] = {s.syn_a, s.gl,
                              irf_phys(s.idx[4:0], s.win_odd)};
         `CLS_FRF: w[19:0] = {s.syn_a[6:0], s.syn_b[6:0],
                              s.idx[5:0]};
         `CLS_TSTACK: w[18:0] = {s.syn_a, s.syn_b, s.idx[2:0]};
         `CLS_SCRATCH: w[10:0] = {s.syn_a, s.idx[2:0]};
         `CLS_TICK: w[9:0] = {s.syn_a, s.idx[1:0]};
         default: w = '0;
      endcase
      return w;
   endfunction : pack_loc

   // Disrupting log has room for the low locator bits only
   function automatic logic [10:0] log_loc(input loc_src_t s);
      logic [47:0] w;
      w = pack_loc(s);
      return w[10:0];
   endfunction : log_loc

   // Corrected kinds are numbered in priority order already
   function automatic logic [7:0] corr_rank(input logic [4:0] kind);
      return (kind >= 5'h01 && kind <= 5'h0b) ? {3'h0, kind} : `RANK_NONE;
   endfunction : corr_rank

   // Recoverable kinds: rank per kind table, ties by code
   function automatic logic [7:0] recov_rank(input logic [4:0] kind);
      logic [2:0] r;
      r = 3'h7;
      case (kind)
         5'h06: r = 3'h1;
         5'h0e, 5'h0f: r = 3'h2;
         5'h10, 5'h11, 5'h14: r = 3'h5;
         5'h01, 5'h02, 5'h03, 5'h04: r = 3'h6;
         5'h13: r = 3'h7;
         default: return `RANK_NONE;
      endcase
      return {r, kind};
   endfunction : recov_rank

   // Precise lanes: lowest priority number wins
   always_comb begin
      sync_hit = 1'h0;
      sync_kind = `KIND_RESET;
      sync_loc = '0;
      if (sync_lane_i[0].vld && (!sync_lane_i[1].vld ||
          sync_lane_i[0].prio <= sync_lane_i[1].prio)) begin
         sync_hit = 1'h1;
         sync_kind = sync_lane_i[0].kind;
         sync_loc = pack_loc(sync_lane_i[0].loc);
      end else if (sync_lane_i[1].vld) begin
         sync_hit = 1'h1;
         sync_kind = sync_lane_i[1].kind;
         sync_loc = pack_loc(sync_lane_i[1].loc);
      end
   end

   // Register decode for the access port
   always_comb begin
      target = ACC_NONE;
      if (acc_asi_i == `ASI_FAULT_LOG && acc_ofs_i == `OFS_ASYNC_LOG) begin
         target = ACC_LOG;
      end else if (acc_asi_i == `ASI_DATA_FAULT) begin
         if (acc_ofs_i == `OFS_KIND_REG) begin
            target = ACC_KIND;
         end else if (acc_ofs_i == `OFS_LOCATOR_REG) begin
            target = ACC_LOCATOR;
         end
      end
   end

   assign rd_log = acc_req_i && !acc_wr_i && target == ACC_LOG;

   // Disrupting log update, one strand per iteration
   always_comb begin
      for (int t = 0; t < `NSTRAND; t++) begin
         async_log_t base;
         logic have_c;
         logic have_r;
         logic [7:0] best_c;
         logic [7:0] best_r;
         async_lane_t lc;
         async_lane_t lr;
         base = async_fault_log[t];
         have_c = 1'h0;
         have_r = 1'h0;
         best_c = `RANK_NONE;
         best_r = `RANK_NONE;
         lc = corr_lane_i[0];
         lr = recov_lane_i[0];
         // A read empties the log; a new error lands on the empty log
         if (rd_log && acc_strand_i == t[2:0]) begin
            base = '0;
         end
         for (int l = 0; l < `ASYNC_LANES; l++) begin
            // Masked errors leave no trace at all
            if (corr_lane_i[l].vld && corr_lane_i[l].rep_en &&
                corr_lane_i[l].strand == t[2:0] &&
                corr_rank(corr_lane_i[l].kind) < best_c) begin
               have_c = 1'h1;
               best_c = corr_rank(corr_lane_i[l].kind);
               lc = corr_lane_i[l];
            end
            if (recov_lane_i[l].vld && recov_lane_i[l].rep_en &&
                recov_lane_i[l].strand == t[2:0] &&
                recov_rank(recov_lane_i[l].kind) < best_r) begin
               have_r = 1'h1;
               best_r = recov_rank(recov_lane_i[l].kind);
               lr = recov_lane_i[l];
            end
         end
         next_log[t] = base;
         if (have_r) begin
            if (!base.valid) begin
               next_log[t].valid = 1'h1;
               next_log[t].recov = 1'h1;
               next_log[t].overrun = base.overrun | have_c;
               next_log[t].kind = lr.kind;
               next_log[t].loc = log_loc(lr.loc);
            end else if (base.recov) begin
               next_log[t].overrun = 1'h1;
            end else begin
               // Recoverable information displaces the corrected one
               next_log[t].recov = 1'h1;
               next_log[t].overrun = 1'h1;
               next_log[t].kind = lr.kind;
               next_log[t].loc = log_loc(lr.loc);
            end
         end else if (have_c) begin
            if (!base.valid) begin
               next_log[t].valid = 1'h1;
               next_log[t].recov = 1'h0;
               next_log[t].kind = lc.kind;
               next_log[t].loc = log_loc(lc.loc);
            end else begin
               next_log[t].overrun = 1'h1;
            end
         end
      end
   end

   // Log is cleared by every reset on resetn_i, through rst_n, warm or power-on
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int t = 0; t < `NSTRAND; t++) begin
            async_fault_log[t] <= '0;
         end
      end else begin
         for (int t = 0; t < `NSTRAND; t++) begin
            async_fault_log[t] <= next_log[t];
         end
      end
   end

   // Fault kind register: capture beats software write
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int t = 0; t < `NSTRAND; t++) begin
            data_fault_kind_reg[t] <= `KIND_RESET;
         end
      end else if (sync_hit) begin
         data_fault_kind_reg[sync_strand_i] <= sync_kind;
      end else if (acc_req_i && acc_wr_i && target == ACC_KIND) begin
         data_fault_kind_reg[acc_strand_i] <= acc_wdata_i[3:0];
      end
   end

   // Store has no reset, so unwritten slots read as zero
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         loc_written <= '0;
      end else if (sync_hit) begin
         loc_written[sync_strand_i] <= 1'h1;
      end
   end

   assign loc_if.wr_en = sync_hit;
   assign loc_if.wr_addr = sync_strand_i;
   assign loc_if.wr_data = sync_loc;
   assign loc_if.rd_addr = acc_strand_i;

   // Read answers one cycle after the request
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_ack_o <= 1'h0;
         acc_err_o <= 1'h0;
         target_q <= ACC_NONE;
         rdata_q <= '0;
         loc_valid_q <= 1'h0;
      end else begin
         acc_ack_o <= acc_req_i;
         acc_err_o <= acc_req_i && target == ACC_NONE;
         target_q <= acc_req_i ? target : ACC_NONE;
         loc_valid_q <= loc_written[acc_strand_i];
         rdata_q <= '0;
         if (acc_req_i && !acc_wr_i) begin
            case (target)
               ACC_LOG: begin
                  // Old contents go back even if an error lands now
                  rdata_q[`LOG_VALID_BIT] <=
                     async_fault_log[acc_strand_i].valid;
                  rdata_q[`LOG_OVERRUN_BIT] <=
                     async_fault_log[acc_strand_i].overrun;
                  rdata_q[`LOG_CLASS_BIT] <=
                     async_fault_log[acc_strand_i].recov;
                  rdata_q[60:56] <= async_fault_log[acc_strand_i].kind;
                  rdata_q[10:0] <= async_fault_log[acc_strand_i].loc;
               end
               ACC_KIND: rdata_q[3:0] <= data_fault_kind_reg[acc_strand_i];
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   // Locator comes straight from the store's output register
   always_comb begin
      acc_rdata_o = rdata_q;
      if (target_q == ACC_LOCATOR) begin
         acc_rdata_o = loc_valid_q ? {16'h0000, loc_if.rd_data} : '0;
      end
   end

   // Trap requests stay high while pending and enabled
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fixed_fault_trap_o <= '0;
         recoverable_fault_trap_o <= '0;
      end else begin
         for (int t = 0; t < `NSTRAND; t++) begin
            fixed_fault_trap_o[t] <= async_fault_log[t].valid &&
               !async_fault_log[t].recov && fixed_trap_on_i[t] &&
               (intr_allow_i[t] || !top_level_mode_i[t]);
            recoverable_fault_trap_o[t] <= async_fault_log[t].valid &&
               async_fault_log[t].recov && recov_trap_on_i[t] &&
               (intr_allow_i[t] || !top_level_mode_i[t]);
         end
      end
   end
endmodule : fault_logger

// [test/fault_logger_props.sv]
// Port-level checks for the fault logger
`timescale 1ns/1ns
`include "fault_log_params.svh"
module fault_logger_props
   import fault_log_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic acc_req_i,
   input wire logic acc_wr_i,
   input wire logic [2:0] acc_strand_i,
   input wire logic [7:0] acc_asi_i,
   input wire logic [7:0] acc_ofs_i,
   input wire logic acc_ack_o,
   input wire logic [63:0] acc_rdata_o,
   input wire async_lane_t [1:0] corr_lane_i,
   input wire async_lane_t [1:0] recov_lane_i,
   input wire logic [7:0] fixed_trap_on_i,
   input wire logic [7:0] recov_trap_on_i,
   input wire logic [7:0] intr_allow_i,
   input wire logic [7:0] top_level_mode_i,
   input wire logic [7:0] fixed_fault_trap_o,
   input wire logic [7:0] recoverable_fault_trap_o
);
   default clocking dcb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic rd, rd_kind, rd_loc, rd_log, quiet;
   logic [7:0] fix_en, rec_en;
   assign rd = acc_req_i && !acc_wr_i;
   assign rd_kind = rd && acc_asi_i == `ASI_DATA_FAULT
      && acc_ofs_i == `OFS_KIND_REG;
   assign rd_loc = rd && acc_asi_i == `ASI_DATA_FAULT
      && acc_ofs_i == `OFS_LOCATOR_REG;
   assign rd_log = rd && acc_asi_i == `ASI_FAULT_LOG
      && acc_ofs_i == `OFS_ASYNC_LOG;
   assign quiet = !(corr_lane_i[0].vld || corr_lane_i[1].vld
      || recov_lane_i[0].vld || recov_lane_i[1].vld);
   // Trap flops follow the gate by exactly one edge
   assign fix_en = fixed_trap_on_i & (intr_allow_i | ~top_level_mode_i);
   assign rec_en = recov_trap_on_i & (intr_allow_i | ~top_level_mode_i);

   property p_ack;
      acc_req_i |=> acc_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_idle;
      !acc_req_i |=> !acc_ack_o && acc_rdata_o == 64'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("stray ack");
   property p_kind_rsvd;
      rd_kind |=> acc_rdata_o[63:4] == 60'h0;
   endproperty
   a_kind_rsvd: assert property (p_kind_rsvd) else $error("kind hi");
   property p_loc_rsvd;
      rd_loc |=> acc_rdata_o[63:48] == 16'h0;
   endproperty
   a_loc_rsvd: assert property (p_loc_rsvd) else $error("loc hi");
   property p_log_rsvd;
      rd_log |=> acc_rdata_o[55:11] == 45'h0;
   endproperty
   a_log_rsvd: assert property (p_log_rsvd) else $error("log mid");
   property p_clear;
      rd_log && quiet ##1 rd_log && quiet && $stable(acc_strand_i)
         |=> acc_rdata_o == 64'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("log kept");
   property p_fix_gate;
      (fixed_fault_trap_o & ~$past(fix_en)) == 8'h0;
   endproperty
   a_fix_gate: assert property (p_fix_gate) else $error("fix trap");
   property p_rec_gate;
      (recoverable_fault_trap_o & ~$past(rec_en)) == 8'h0;
   endproperty
   a_rec_gate: assert property (p_rec_gate) else $error("rec trap");
   property p_excl;
      (fixed_fault_trap_o & recoverable_fault_trap_o) == 8'h0;
   endproperty
   a_excl: assert property (p_excl) else $error("both traps");
endmodule : fault_logger_props

bind fault_logger fault_logger_props u_props (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .acc_req_i(acc_req_i),
   .acc_wr_i(acc_wr_i), .acc_strand_i(acc_strand_i),
   .acc_asi_i(acc_asi_i), .acc_ofs_i(acc_ofs_i), .acc_ack_o(acc_ack_o),
   .acc_rdata_o(acc_rdata_o), .corr_lane_i(corr_lane_i),
   .recov_lane_i(recov_lane_i), .fixed_trap_on_i(fixed_trap_on_i),
   .recov_trap_on_i(recov_trap_on_i), .intr_allow_i(intr_allow_i),
   .top_level_mode_i(top_level_mode_i),
   .fixed_fault_trap_o(fixed_fault_trap_o),
   .recoverable_fault_trap_o(recoverable_fault_trap_o)
);

// [test/fault_src_model.sv]
// Error detector model driving one-cycle fault strobes
`timescale 1ns/1ns
module fault_src_model
   import fault_log_pkg::*;
(
   input wire logic clk_i,
   output logic [2:0] sync_strand_o,
   output sync_lane_t [1:0] sync_lane_o,
   output async_lane_t [1:0] corr_lane_o,
   output async_lane_t [1:0] recov_lane_o
);
   initial begin
      sync_strand_o = 3'h0;
      sync_lane_o = '0;
      corr_lane_o = '0;
      recov_lane_o = '0;
   end
   // Stale fields toggle so nothing can lean on them
   always @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         sync_lane_o[i] <= ~sync_lane_o[i];
         sync_lane_o[i].vld <= 1'b0;
         corr_lane_o[i] <= ~corr_lane_o[i];
         corr_lane_o[i].vld <= 1'b0;
         recov_lane_o[i] <= ~recov_lane_o[i];
         recov_lane_o[i].vld <= 1'b0;
      end
   end
   task automatic fs(input int l, input logic [2:0] st,
         input logic [3:0] p, input logic [3:0] k, input loc_src_t s);
      sync_strand_o = st;
      sync_lane_o[l] = '{1'b1, k, p, s};
   endtask : fs
   task automatic fa(input logic r, input int l, input logic [2:0] st,
         input logic [4:0] k, input logic en, input logic [3:0] c,
         input logic [6:0] x);
      async_lane_t v;
      v = '{1'b1, st, k, en, '{c, 48'h0, x, 3'h0, 8'h0, 8'h0, 2'h0, 1'b0}};
      if (r) begin
         recov_lane_o[l] = v;
      end else begin
         corr_lane_o[l] = v;
      end
   endtask : fa
endmodule : fault_src_model

// [test/fault_logger_tb.sv]
// Self-checking bench for the fault logger
`timescale 1ns/1ns
`include "fault_log_params.svh"
module fault_logger_tb
   import fault_log_pkg::*;
;
   localparam logic [47:0] VA = 48'ha5c3_0f96_1e2d;
   localparam logic [63:0] LM = 64'hff00_0000_0000_0007;
   localparam logic [63:0] HM = 64'hff00_0000_0000_0000;
   localparam int LIMIT = 2000;
   logic core_clk_i, resetn_i, acc_req_i, acc_wr_i, acc_ack_o, acc_err_o;
   logic er;
   logic [2:0] acc_strand_i, sync_strand_i;
   logic [7:0] acc_asi_i, acc_ofs_i, fixed_trap_on_i, recov_trap_on_i;
   logic [7:0] intr_allow_i, top_level_mode_i;
   logic [7:0] fixed_fault_trap_o, recoverable_fault_trap_o;
   logic [63:0] acc_wdata_i, acc_rdata_o, rd;
   sync_lane_t [1:0] sync_lane_i;
   async_lane_t [1:0] corr_lane_i, recov_lane_i;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   fault_src_model src (.clk_i(core_clk_i), .sync_strand_o(sync_strand_i),
      .sync_lane_o(sync_lane_i), .corr_lane_o(corr_lane_i),
      .recov_lane_o(recov_lane_i));
   fault_logger uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .acc_req_i(acc_req_i), .acc_wr_i(acc_wr_i),
      .acc_strand_i(acc_strand_i), .acc_asi_i(acc_asi_i),
      .acc_ofs_i(acc_ofs_i), .acc_wdata_i(acc_wdata_i),
      .acc_ack_o(acc_ack_o), .acc_err_o(acc_err_o),
      .acc_rdata_o(acc_rdata_o), .sync_strand_i(sync_strand_i),
      .sync_lane_i(sync_lane_i), .corr_lane_i(corr_lane_i),
      .recov_lane_i(recov_lane_i), .fixed_trap_on_i(fixed_trap_on_i),
      .recov_trap_on_i(recov_trap_on_i), .intr_allow_i(intr_allow_i),
      .top_level_mode_i(top_level_mode_i),
      .fixed_fault_trap_o(fixed_fault_trap_o),
      .recoverable_fault_trap_o(recoverable_fault_trap_o));

   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end

   task automatic print_verdict();
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      acc_req_i = 1'b0;
      repeat (n) @(negedge core_clk_i);
   endtask : wt
   // Called just after a falling edge; returns one cycle later
   // Request stays up so back-to-back calls never glitch it
   task automatic acc(input logic w, input logic [2:0] s,
         input logic [7:0] a, input logic [7:0] o, input logic [63:0] d);
      {acc_req_i, acc_wr_i, acc_strand_i, acc_asi_i, acc_ofs_i} =
         {1'b1, w, s, a, o};
      acc_wdata_i = d;
      @(negedge core_clk_i);
      rd = acc_rdata_o;
      er = acc_err_o;
   endtask : acc
   task automatic rl(input logic [2:0] s, input logic [63:0] m,
         input logic [63:0] e);
      acc(1'b0, s, `ASI_FAULT_LOG, `OFS_ASYNC_LOG, 64'h0);
      chk(rd & m, e);
   endtask : rl
   function automatic logic [63:0] lg(input logic [2:0] f,
         input logic [4:0] k, input logic [2:0] l);
      lg = {f, k, 53'h0, l};
   endfunction : lg
   task automatic tc(input logic [1:0] e);
      wt(3);
      chk({62'h0, fixed_fault_trap_o[2], recoverable_fault_trap_o[2]},
         {62'h0, e});
   endtask : tc
   task automatic ts(input logic [3:0] c, input logic [6:0] x,
         input logic [2:0] w, input logic [7:0] y, input logic [1:0] g,
         input logic od, input logic [63:0] m, input logic [63:0] e);
      src.fs(0, 3'h1, 4'h3, 4'h2, '{c, VA, x, w, y, ~y, g, od});
      wt(1);
      acc(1'b0, 3'h1, `ASI_DATA_FAULT, `OFS_LOCATOR_REG, 64'h0);
      chk(rd & m, e);
   endtask : ts

   initial begin
      {resetn_i, acc_wr_i, acc_strand_i} = '0;
      {acc_asi_i, acc_ofs_i, acc_wdata_i} = '0;
      {fixed_trap_on_i, recov_trap_on_i, intr_allow_i} = '0;
      top_level_mode_i = 8'hff;
      wt(20);
      resetn_i = 1'b1;
      wt(3);
      rl(3'h5, '1, 64'h0);
      acc(1'b1, 3'h3, `ASI_DATA_FAULT, `OFS_KIND_REG, '1);
      acc(1'b0, 3'h3, `ASI_DATA_FAULT, `OFS_KIND_REG, 64'h0);
      chk(rd, 64'hf);
      acc(1'b1, 3'h3, `ASI_DATA_FAULT, `OFS_LOCATOR_REG, '1);
      acc(1'b0, 3'h3, `ASI_DATA_FAULT, `OFS_LOCATOR_REG, 64'h0);
      chk(rd, 64'h0);
      acc(1'b0, 3'h3, `ASI_FAULT_LOG, 8'h38, 64'h0);
      chk({63'h0, er}, 64'h1);
      chk(rd, 64'h0);
      ts(`CLS_XLATE, 7'h00, 3'h0, 8'h00, 2'h0, 1'b0, '1, {16'h0, VA});
      ts(`CLS_WALK_CFG, 7'h05, 3'h0, 8'h00, 2'h0, 1'b0, 64'h7, 64'h5);
      ts(`CLS_ICACHE, 7'h2b, 3'h6, 8'h00, 2'h0, 1'b0, 64'h1ff, 64'h1ab);
      ts(`CLS_DCACHE, 7'h5a, 3'h2, 8'h00, 2'h0, 1'b0, 64'h1ff, 64'h15a);
      ts(`CLS_STB, 7'h03, 3'h0, 8'h00, 2'h0, 1'b0, 64'h7, 64'h3);
      ts(`CLS_CFG_ARRAY, 7'h06, 3'h0, 8'h00, 2'h0, 1'b0, 64'h7, 64'h6);
      ts(`CLS_IRF, 7'h0b, 3'h0, 8'hc5, 2'h2, 1'b1, 64'h7fff, 64'h62db);
      ts(`CLS_IRF, 7'h19, 3'h0, 8'h3c, 2'h1, 1'b0, 64'h7fff, 64'h1e39);
      ts(`CLS_IRF, 7'h14, 3'h0, 8'h00, 2'h0, 1'b1, 64'h7fff, 64'h14);
      ts(`CLS_IRF, 7'h02, 3'h0, 8'h01, 2'h0, 1'b1, 64'h7fff, 64'h82);
      ts(`CLS_FRF, 7'h2d, 3'h0, 8'h55, 2'h0, 1'b0,
         64'hfffff, 64'haaaad);
      ts(`CLS_TSTACK, 7'h05, 3'h0, 8'h96, 2'h0, 1'b0,
         64'h7ffff, 64'h4b34d);
      ts(`CLS_SCRATCH, 7'h03, 3'h0, 8'h96, 2'h0, 1'b0,
         64'h7ff, 64'h4b3);
      ts(`CLS_TICK, 7'h02, 3'h0, 8'h96, 2'h0, 1'b0, 64'h3ff, 64'h25a);
      src.fs(0, 3'h1, 4'h4, 4'h7,
         '{`CLS_STB, VA, 7'h01, 3'h0, 8'h0, 8'h0, 2'h0, 1'b0});
      src.fs(1, 3'h1, 4'h1, 4'h9,
         '{`CLS_STB, VA, 7'h06, 3'h0, 8'h0, 8'h0, 2'h0, 1'b0});
      wt(1);
      acc(1'b0, 3'h1, `ASI_DATA_FAULT, `OFS_KIND_REG, 64'h0);
      chk(rd, 64'h9);
      acc(1'b0, 3'h1, `ASI_DATA_FAULT, `OFS_LOCATOR_REG, 64'h0);
      chk(rd & 64'h7, 64'h6);
      src.fa(1'b0, 0, 3'h2, 5'h01, 1'b0, `CLS_ICACHE, 7'h01);
      wt(1);
      rl(3'h2, '1, 64'h0);
      src.fa(1'b0, 0, 3'h2, 5'h03, 1'b1, `CLS_ICACHE, 7'h05);
      tc(2'b00);
      fixed_trap_on_i[2] = 1'b1;
      tc(2'b00);
      intr_allow_i[2] = 1'b1;
      tc(2'b10);
      src.fa(1'b0, 1, 3'h2, 5'h05, 1'b1, `CLS_DCACHE, 7'h01);
      wt(1);
      rl(3'h2, LM, lg(3'b110, 5'h03, 3'h5));
      tc(2'b00);
      src.fa(1'b0, 0, 3'h2, 5'h07, 1'b1, `CLS_DCACHE, 7'h04);
      wt(1);
      src.fa(1'b1, 1, 3'h2, 5'h06, 1'b1, `CLS_STB, 7'h02);
      tc(2'b00);
      recov_trap_on_i[2] = 1'b1;
      tc(2'b01);
      src.fa(1'b1, 0, 3'h2, 5'h10, 1'b1, `CLS_MEMORY, 7'h07);
      wt(1);
      rl(3'h2, LM, lg(3'b111, 5'h06, 3'h2));
      rl(3'h2, '1, 64'h0);
      tc(2'b00);
      src.fa(1'b1, 0, 3'h2, 5'h06, 1'b1, `CLS_STB, 7'h04);
      wt(1);
      src.fa(1'b0, 0, 3'h2, 5'h02, 1'b1, `CLS_ICACHE, 7'h03);
      rl(3'h2, LM, lg(3'b101, 5'h06, 3'h4));
      rl(3'h2, LM, lg(3'b100, 5'h02, 3'h3));
      src.fa(1'b0, 0, 3'h2, 5'h01, 1'b1, `CLS_ICACHE, 7'h01);
      src.fa(1'b1, 0, 3'h2, 5'h06, 1'b1, `CLS_STB, 7'h06);
      tc(2'b01);
      rl(3'h2, LM, lg(3'b111, 5'h06, 3'h6));
      src.fa(1'b1, 0, 3'h2, 5'h13, 1'b1, `CLS_MEMORY, 7'h00);
      src.fa(1'b1, 1, 3'h2, 5'h10, 1'b1, `CLS_MEMORY, 7'h00);
      wt(1);
      rl(3'h2, HM, lg(3'b101, 5'h10, 3'h0));
      src.fa(1'b0, 0, 3'h2, 5'h08, 1'b1, `CLS_DCACHE, 7'h01);
      src.fa(1'b0, 1, 3'h2, 5'h02, 1'b1, `CLS_ICACHE, 7'h03);
      wt(1);
      rl(3'h2, LM, lg(3'b100, 5'h02, 3'h3));
      wt(2);
      print_verdict();
   end
endmodule : fault_logger_tb
